// [hw/serial_comm_block.v]
// Purpose: Asynchronous serial channel with APB registers, handshake lines and interrupt.
// Assumes: 100 MHz clk_sys, rst_n asynchronous active low, APB master on the same clock.
// Notes: Settings written to CFG and DIV are staged and applied only at reset or apply.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "serial_comm_block_regs.vh"

module serial_comm_block
(
	input  wire        clk_sys,
	input  wire        rst_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	input  wire        usb_suspend,
	input  wire        rxd,
	input  wire        cts_n,
	input  wire        dsr_n,
	output reg         txd,
	output reg         rts_n,
	output reg         dtr_n,
	output wire        cts_pullup_en,
	output wire        dsr_pullup_en,
	output wire        irq
);

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	// Parity bit for the chosen mode over 7 or 8 data bits.
	function par_bit;
		input [7:0] d;
		input       w7;
		input [2:0] mode;
		reg         x;
		begin
			x = w7 ? ^d[6:0] : ^d;
			case (mode)
				`SCB_PAR_ODD:  par_bit = ~x;
				`SCB_PAR_EVEN: par_bit = x;
				`SCB_PAR_MARK: par_bit = 1'b1;
				default:       par_bit = 1'b0;
			endcase
		end
	endfunction

	// Bits in a frame after the start bit: data, parity, stops.
	function [3:0] frame_bits;
		input       w7;
		input [2:0] mode;
		input       s2;
		begin
			frame_bits = (w7 ? 4'd7 : 4'd8) + ((mode == `SCB_PAR_NONE) ? 4'd0 : 4'd1)
				+ (s2 ? 4'd2 : 4'd1);
		end
	endfunction

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	reg [2:0] sync1_q;
	reg [2:0] sync2_q;

	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_q <= 3'h7;
			sync2_q <= 3'h7;
		end
		else
		begin
			sync1_q <= {dsr_n, cts_n, rxd};
			sync2_q <= sync1_q;
		end
	end

	wire rxd_s = sync2_q[0];
	wire cts_s = ~sync2_q[1];
	wire dsr_s = ~sync2_q[2];

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	reg  [8:0]  cfg_stage_q;
	reg  [8:0]  cfg_q;
	reg  [15:0] div_stage_q;
	reg  [15:0] div_q;
	reg  [1:0]  ctrl_q;
	reg  [3:0]  irq_stat_q;
	reg  [3:0]  irq_en_q;
	reg  [7:0]  rx_data_q;
	reg         rx_valid_q;

	wire acc    = psel & penable;
	wire wr     = acc & pwrite;
	wire rd_acc = acc & ~pwrite;
	wire apply  = wr && paddr == `SCB_OFF_CTRL && pwdata[`SCB_CTRL_APPLY];

	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	wire [1:0] if_type = cfg_q[`SCB_CFG_TYPE_LSB +: 2];
	wire       w7      = cfg_q[`SCB_CFG_WIDTH7];
	wire       stop2   = cfg_q[`SCB_CFG_STOP2];
	wire [2:0] pmode   = cfg_q[`SCB_CFG_PAR_LSB +: 3];
	wire       drop    = cfg_q[`SCB_CFG_DROP];
	wire       susp_pu = cfg_q[`SCB_CFG_SUSP_PU];
	wire [3:0] nbits   = frame_bits(w7, pmode, stop2);

	// Divisor writes below the 3 Mbps floor are clamped.
	wire [15:0] div_wr = (pwdata[15:0] < `SCB_DIV_MIN_W) ? `SCB_DIV_MIN_W : pwdata[15:0];

	wire tx_start;
	wire tx_done;
	wire rx_done;
	wire rx_err;
	wire rx_keep;

	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_stage_q <= `SCB_CFG_RESET;
			cfg_q       <= `SCB_CFG_RESET;
			div_stage_q <= `SCB_DEF_DIV_W;
			div_q       <= `SCB_DEF_DIV_W;
			ctrl_q      <= 2'h0;
			irq_en_q    <= 4'h0;
		end
		else
		begin
			if (wr && paddr == `SCB_OFF_CFG)
				cfg_stage_q <= pwdata[8:0];
			if (wr && paddr == `SCB_OFF_DIV)
				div_stage_q <= div_wr;
			if (wr && paddr == `SCB_OFF_CTRL)
				ctrl_q <= pwdata[1:0];
			if (wr && paddr == `SCB_OFF_IRQ_EN)
				irq_en_q <= pwdata[3:0];
			if (apply)
			begin
				cfg_q <= cfg_stage_q;
				div_q <= div_stage_q;
			end
		end
	end

	// Sticky events: a set in the same cycle as a clear wins.
	wire       rd_rx = rd_acc && paddr == `SCB_OFF_RXDATA;
	wire [3:0] ev = {rx_done & rx_valid_q & rx_keep & ~rd_rx, rx_err, tx_done, rx_done & rx_keep};
	wire [3:0] clr = (wr && paddr == `SCB_OFF_IRQ_CLR) ? pwdata[3:0] : 4'h0;

	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			irq_stat_q <= 4'h0;
		else
			irq_stat_q <= (irq_stat_q & ~clr) | ev;
	end

	assign irq = |(irq_stat_q & irq_en_q);

	wire tx_busy;

	always @*
	begin
		prdata = 32'h0;
		if (rd_acc)
		begin
			case (paddr)
				`SCB_OFF_CFG:      prdata = {23'h0, cfg_stage_q};
				`SCB_OFF_DIV:      prdata = {16'h0, div_stage_q};
				`SCB_OFF_RXDATA:   prdata = {24'h0, rx_data_q};
				`SCB_OFF_STATUS:   prdata = {28'h0, dsr_s, cts_s, rx_valid_q, tx_busy};
				`SCB_OFF_IRQ_STAT: prdata = {28'h0, irq_stat_q};
				`SCB_OFF_IRQ_EN:   prdata = {28'h0, irq_en_q};
				`SCB_OFF_CTRL:     prdata = {30'h0, ctrl_q};
				`SCB_OFF_ACTIVE:   prdata = {7'h0, cfg_q, div_q};
				default:           prdata = 32'h0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Handshake outputs and pull-ups
	// ------------------------------------------------------------
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rts_n <= 1'b1;
			dtr_n <= 1'b1;
		end
		else
		begin
			rts_n <= ~(ctrl_q[`SCB_CTRL_RTS] && if_type != `SCB_TYPE_2PIN);
			dtr_n <= ~(ctrl_q[`SCB_CTRL_DTR] && if_type == `SCB_TYPE_6PIN);
		end
	end

	assign cts_pullup_en = ~(susp_pu & usb_suspend);
	assign dsr_pullup_en = ~(susp_pu & usb_suspend);

	// ------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------
	reg [15:0] tx_cnt_q;
	reg [3:0]  tx_bit_q;
	reg [10:0] tx_sh_q;
	reg        tx_act_q;

	// Outside 2-pin mode, flow control holds the start of a new character while CTS is off.
	wire cts_ok = (if_type == `SCB_TYPE_2PIN) | cts_s;
	assign tx_start = wr && paddr == `SCB_OFF_TXDATA && !tx_act_q;
	assign tx_busy  = tx_act_q;
	assign tx_done  = tx_act_q && tx_cnt_q == 16'h0 && tx_bit_q == nbits;

	reg [10:0] tx_frame;
	always @*
	begin
		tx_frame = 11'h7FF;
		if (w7)
			tx_frame[6:0] = pwdata[6:0];
		else
			tx_frame[7:0] = pwdata[7:0];
		if (pmode != `SCB_PAR_NONE)
			tx_frame[w7 ? 7 : 8] = par_bit(pwdata[7:0], w7, pmode);
	end

	reg tx_pend_q;
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_cnt_q  <= 16'h0;
			tx_bit_q  <= 4'h0;
			tx_sh_q   <= 11'h7FF;
			tx_act_q  <= 1'b0;
			tx_pend_q <= 1'b0;
			txd       <= 1'b1;
		end
		else if (tx_start)
		begin
			tx_sh_q   <= tx_frame;
			tx_act_q  <= 1'b1;
			tx_pend_q <= 1'b1;
			tx_bit_q  <= 4'h0;
			tx_cnt_q  <= 16'h0;
		end
		else if (tx_pend_q)
		begin
			if (cts_ok)
			begin
				tx_pend_q <= 1'b0;
				txd       <= 1'b0;
				tx_cnt_q  <= div_q - 16'h1;
			end
		end
		else if (tx_act_q)
		begin
			if (tx_cnt_q != 16'h0)
				tx_cnt_q <= tx_cnt_q - 16'h1;
			else if (tx_bit_q == nbits)
			begin
				tx_act_q <= 1'b0;
				txd      <= 1'b1;
			end
			else
			begin
				txd      <= tx_sh_q[0];
				tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
				tx_bit_q <= tx_bit_q + 4'h1;
				tx_cnt_q <= div_q - 16'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------
	reg [15:0] rx_cnt_q;
	reg [3:0]  rx_bit_q;
	reg [10:0] rx_sh_q;
	reg        rx_act_q;
	reg        rx_prev_q;
	reg        rx_done_q;

	// Frame as received, shifted down so bit 0 is the first data bit.
	wire [10:0] rx_fr   = rx_sh_q >> (4'd11 - nbits);
	wire [7:0]  rx_byte = w7 ? {1'b0, rx_fr[6:0]} : rx_fr[7:0];
	wire        rx_par  = w7 ? rx_fr[7] : rx_fr[8];
	wire [3:0]  stop_ix = (w7 ? 4'd7 : 4'd8) + ((pmode == `SCB_PAR_NONE) ? 4'd0 : 4'd1);
	wire        par_bad = (pmode != `SCB_PAR_NONE) && rx_par != par_bit(rx_byte, w7, pmode);
	wire        stop_bad = !rx_fr[stop_ix] || (stop2 && !rx_fr[stop_ix + 4'd1]);
	wire        rx_bad   = par_bad || stop_bad;

	assign rx_done = rx_done_q;
	assign rx_err  = rx_done_q && rx_bad;
	assign rx_keep = !(drop && rx_bad);

	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_cnt_q  <= 16'h0;
			rx_bit_q  <= 4'h0;
			rx_sh_q   <= 11'h0;
			rx_act_q  <= 1'b0;
			rx_prev_q <= 1'b1;
			rx_done_q <= 1'b0;
		end
		else
		begin
			rx_prev_q <= rxd_s;
			rx_done_q <= 1'b0;
			if (!rx_act_q)
			begin
				if (rx_prev_q && !rxd_s)
				begin
					rx_act_q <= 1'b1;
					rx_bit_q <= 4'h0;
					rx_cnt_q <= div_q + {1'b0, div_q[15:1]} - 16'h1;
				end
			end
			else if (rx_cnt_q != 16'h0)
				rx_cnt_q <= rx_cnt_q - 16'h1;
			else
			begin
				rx_sh_q  <= {rxd_s, rx_sh_q[10:1]};
				rx_bit_q <= rx_bit_q + 4'h1;
				rx_cnt_q <= div_q - 16'h1;
				if (rx_bit_q == nbits - 4'h1)
				begin
					rx_act_q  <= 1'b0;
					rx_done_q <= 1'b1;
				end
			end
		end
	end

	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_data_q  <= 8'h0;
			rx_valid_q <= 1'b0;
		end
		else
		begin
			if (rx_done_q && rx_keep)
			begin
				rx_data_q  <= rx_byte;
				rx_valid_q <= 1'b1;
			end
			else if (rd_rx)
				rx_valid_q <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// [hw/serial_comm_block_regs.vh]
// Purpose: Register map, field positions, reset values and timing counts of the serial channel.
// Assumes: 100 MHz system clock, 32-bit APB, word-aligned registers.
// Notes: Included by the channel module only.
`ifndef SERIAL_COMM_BLOCK_REGS_VH
`define SERIAL_COMM_BLOCK_REGS_VH

`define SCB_CLK_HZ          100000000
`define SCB_DEF_BAUD        115200
`define SCB_MIN_BAUD        300
`define SCB_MAX_BAUD        3000000
// Divisor is clock cycles per bit.
`define SCB_DEF_DIV         (`SCB_CLK_HZ / `SCB_DEF_BAUD)
`define SCB_DIV_MIN         (`SCB_CLK_HZ / `SCB_MAX_BAUD)
// The same two divisors at register width.
`define SCB_DEF_DIV_W       16'h0364
`define SCB_DIV_MIN_W       16'h0021

`define SCB_OFF_CFG         12'h000
`define SCB_OFF_DIV         12'h004
`define SCB_OFF_TXDATA      12'h008
`define SCB_OFF_RXDATA      12'h00C
`define SCB_OFF_STATUS      12'h010
`define SCB_OFF_IRQ_STAT    12'h014
`define SCB_OFF_IRQ_EN      12'h018
`define SCB_OFF_IRQ_CLR     12'h01C
`define SCB_OFF_CTRL        12'h020
`define SCB_OFF_ACTIVE      12'h024

// Configuration fields.
`define SCB_CFG_TYPE_LSB    0
`define SCB_CFG_WIDTH7      2
`define SCB_CFG_STOP2       3
`define SCB_CFG_PAR_LSB     4
`define SCB_CFG_DROP        7
`define SCB_CFG_SUSP_PU     8
`define SCB_CFG_RESET       9'h102

`define SCB_TYPE_2PIN       2'h0
`define SCB_TYPE_4PIN       2'h1
`define SCB_TYPE_6PIN       2'h2

`define SCB_PAR_NONE        3'h0
`define SCB_PAR_ODD         3'h1
`define SCB_PAR_EVEN        3'h2
`define SCB_PAR_MARK        3'h3
`define SCB_PAR_SPACE       3'h4

// Control fields.
`define SCB_CTRL_RTS        0
`define SCB_CTRL_DTR        1
`define SCB_CTRL_APPLY      2

// Status and interrupt fields.
`define SCB_ST_TX_BUSY      0
`define SCB_ST_RX_VALID     1
`define SCB_ST_CTS          2
`define SCB_ST_DSR          3
`define SCB_IRQ_RX_DONE     0
`define SCB_IRQ_TX_DONE     1
`define SCB_IRQ_RX_ERR      2
`define SCB_IRQ_OVERRUN     3

`endif

// [tb/serial_comm_block_properties.sv]
// Purpose: Port-level assertions for the serial channel.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Bound to the channel from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module serial_comm_block_properties
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic usb_suspend,
	input wire logic txd,
	input wire logic rts_n,
	input wire logic dtr_n,
	input wire logic cts_pullup_en,
	input wire logic dsr_pullup_en,
	input wire logic irq
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// Line framing and port relations
	// ----------------------------------------
	sequence start_edge;
		$fell(txd);
	endsequence
	sequence start_hold;
		!txd [*8];
	endsequence
	a_idle_after_reset: assert property ($rose(rst_n) |-> txd)
		else $error("serial line not idle after reset");
	a_irq_after_reset: assert property ($rose(rst_n) |-> !irq)
		else $error("interrupt raised right after reset");
	a_hs_reset_idle: assert property ($rose(rst_n) |-> rts_n && dtr_n)
		else $error("handshake outputs active after reset");
	a_pullup_awake: assert property (!usb_suspend [*2] |-> cts_pullup_en && dsr_pullup_en)
		else $error("pull-ups off while awake");
	a_pullup_pair: assert property (cts_pullup_en == dsr_pullup_en)
		else $error("pull-up enables disagree");
	a_bit_min_width: assert property ($changed(txd) |=> $stable(txd) [*8])
		else $error("serial bit shorter than minimum divisor");
	a_low_bit_hold: assert property (start_edge |=> start_hold)
		else $error("low bit too short");
	a_apb_ready: assert property (psel && penable |-> pready && !pslverr)
		else $error("register access not answered at once");
endmodule
`default_nettype wire

// [tb/serial_terminal_model.sv]
// Purpose: Remote terminal and line driver on the far side of the channel.
// Assumes: Bit time is given in system clock cycles by the caller.
// Notes: Handshake outputs are looped back to the handshake inputs.
`timescale 1ns/1ps
`default_nettype none
module serial_terminal_model
(
	input  wire logic clk_sys,
	input  wire logic txd,
	input  wire logic rts_n,
	input  wire logic dtr_n,
	output var  logic rxd,
	output wire logic cts_n,
	output wire logic dsr_n
);
	// ----------------------------------------
	// Loopback and framing
	// ----------------------------------------
	initial rxd = 1'b1;
	assign cts_n = rts_n;
	assign dsr_n = dtr_n;
	task automatic send(input logic [11:0] b, input int n, input int div);
		int i;
		for (i = 0; i < n; i++)
		begin
			rxd <= b[i];
			repeat (div) @(posedge clk_sys);
		end
		rxd <= 1'b1;
	endtask
	task automatic capture(input int div, input int n, output logic [11:0] b);
		int i;
		b = 12'hFFF;
		@(negedge txd);
		repeat (div / 2) @(posedge clk_sys);
		for (i = 0; i < n; i++)
		begin
			b[i] = txd;
			repeat (div) @(posedge clk_sys);
		end
	endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// Purpose: Self-checking bench for the serial channel.
// Assumes: 100 MHz clock, APB slave with zero wait states.
// Notes: Random bytes and settings come from a fixed seed.
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [11:0] A_CFG = 12'h000, A_DIV = 12'h004, A_TX = 12'h008, A_RX = 12'h00C;
	localparam logic [11:0] A_ST = 12'h010, A_IST = 12'h014, A_IEN = 12'h018, A_ICLR = 12'h01C;
	localparam logic [11:0] A_CTRL = 12'h020, A_ACT = 12'h024;
	localparam logic [31:0] DEF = 32'h0102_0364;
	localparam int DIV = 40;
	logic        clk_sys = 1'b0, rst_n = 1'b0, usb_suspend = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000, got;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic        pready, pslverr, rxd, cts_n, dsr_n, txd, rts_n, dtr_n, cts_pu, dsr_pu, irq;
	logic [8:0]  cfg;
	logic [7:0]  d;
	int          n_errors = 0, checks = 0, cyc = 0, p;
	always #5 clk_sys = ~clk_sys;
	serial_comm_block serial_comm_block_inst (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .usb_suspend(usb_suspend), .rxd(rxd),
		.cts_n(cts_n), .dsr_n(dsr_n), .txd(txd), .rts_n(rts_n), .dtr_n(dtr_n),
		.cts_pullup_en(cts_pu), .dsr_pullup_en(dsr_pu), .irq(irq));
	serial_terminal_model serial_terminal_model_inst (.clk_sys(clk_sys), .txd(txd),
		.rts_n(rts_n), .dtr_n(dtr_n), .rxd(rxd), .cts_n(cts_n), .dsr_n(dsr_n));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1)
			@(posedge clk_sys);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	function automatic logic [11:0] fbits(input logic [7:0] v, input logic [8:0] c);
		logic [11:0] f;
		int i, k;
		f = 12'hFFF;
		k = c[2] ? 7 : 8;
		v = c[2] ? {1'b0, v[6:0]} : v;
		f[0] = 1'b0;
		for (i = 0; i < k; i++)
			f[i + 1] = v[i];
		if (c[6:4] != 3'h0)
			f[k + 1] = (c[6:4] == 3'h1) ? ~^v : (c[6:4] == 3'h2) ? ^v : (c[6:4] == 3'h3);
		return f;
	endfunction
	function automatic int flen(input logic [8:0] c);
		return 2 + (c[2] ? 7 : 8) + int'(c[6:4] != 3'h0) + int'(c[3]);
	endfunction
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_errors++;
			tally_and_finish;
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		void'($urandom(32'h3558));
		apb(0, A_ACT, 0);
		chk("active defaults", DEF, r);
		usb_suspend <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk("pullups suspended", 0, {cts_pu, dsr_pu});
		usb_suspend <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk("pullups awake", 3, {cts_pu, dsr_pu});
		apb(1, A_DIV, DIV);
		apb(0, A_ACT, 0);
		chk("staged divisor", DEF, r);
		$display("test defaults done");
		for (p = 0; p < 5; p++)
		begin
			cfg = {2'b10, p[2:0], 2'($urandom), 2'h2};
			d = 8'($urandom);
			apb(1, A_CFG, {23'h0, cfg});
			apb(1, A_CTRL, 32'h7);
			apb(0, A_ACT, 0);
			chk("active applied", {7'h0, cfg, 16'd40}, r);
			fork
				serial_terminal_model_inst.capture(DIV, flen(cfg), got);
				apb(1, A_TX, {24'h0, d});
			join
			chk("tx frame", {20'h0, fbits(d, cfg)}, {20'h0, got});
			serial_terminal_model_inst.send(fbits(d ^ 8'h5A, cfg), flen(cfg), DIV);
			repeat (2 * DIV) @(posedge clk_sys);
			apb(0, A_RX, 0);
			chk("rx byte", (d ^ 8'h5A) & (cfg[2] ? 8'h7F : 8'hFF), r[7:0]);
			$display("test frame mode %0d done", p);
		end
		chk("handshake out", 0, {rts_n, dtr_n});
		apb(0, A_ST, 0);
		chk("handshake in", 3, r[3:2]);
		apb(1, A_CFG, 32'h101);
		apb(1, A_CTRL, 32'h7);
		@(posedge clk_sys);
		chk("handshake 4 pin", 1, {rts_n, dtr_n});
		apb(1, A_CFG, 32'h100);
		apb(1, A_CTRL, 32'h7);
		@(posedge clk_sys);
		chk("handshake 2 pin", 3, {rts_n, dtr_n});
		cfg = 9'h1A2;
		apb(1, A_CFG, {23'h0, cfg});
		apb(1, A_CTRL, 32'h7);
		apb(1, A_ICLR, 32'hF);
		apb(1, A_IEN, 32'h4);
		serial_terminal_model_inst.send(fbits(8'h3C, cfg) ^ 12'h200, flen(cfg), DIV);
		repeat (2 * DIV) @(posedge clk_sys);
		chk("irq on parity error", 1, irq);
		apb(0, A_ST, 0);
		chk("dropped byte", 0, r[1]);
		apb(1, A_ICLR, 32'hF);
		chk("irq cleared", 0, irq);
		apb(1, A_IEN, 0);
		serial_terminal_model_inst.send(fbits(8'h3C, cfg) ^ 12'h400, flen(cfg), DIV);
		repeat (2 * DIV) @(posedge clk_sys);
		chk("irq masked", 0, irq);
		apb(0, A_IST, 0);
		chk("stop error flag", 1, r[2]);
		apb(0, 12'h3F0, 0);
		chk("unmapped read", 0, r);
		$display("test errors done");
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		apb(0, A_ACT, 0);
		chk("defaults after reset", DEF, r);
		$display("test reset done");
		tally_and_finish;
	end
endmodule
bind serial_comm_block serial_comm_block_properties serial_comm_block_properties_inst (
	.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .usb_suspend(usb_suspend), .txd(txd), .rts_n(rts_n), .dtr_n(dtr_n),
	.cts_pullup_en(cts_pullup_en), .dsr_pullup_en(dsr_pullup_en), .irq(irq));
`default_nettype wire
